// ==== logic/pscs_pkg.sv ====
`default_nettype none
package pscs_pkg;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int T_REQ_LOW_NS    = 500;
  localparam int T_STATUS_LOW_US = 45;
  localparam int T_REQ2CLK_US    = 230;
  localparam int T_ST2CLK_US     = 2;
  localparam int T_DONE2USER_US  = 300;
  localparam int REQ_LOW_CYC     = (T_REQ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_LOW_CYC  = (T_STATUS_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REQ2CLK_CYC     = (T_REQ2CLK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ST2CLK_CYC      = (T_ST2CLK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CYC     = (T_DONE2USER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int USER_CLK_CYCLES = 3192;
  localparam int DONE_FALL_EDGES = 2;
  localparam int PRE_USER_PERIODS = 4;
  localparam int FMAX_LO_MHZ     = 66;
  localparam int SCLK_HALF_CYC   = 4;
  localparam int MIN_HALF_CYC    = (1000 / FMAX_LO_MHZ) / (2 * CLK_PERIOD_NS) + 1;
  localparam int CNT_W           = 16;
  localparam int POR_CYC_DEF     = 1000;
  localparam int BYTES_DEF       = 16;
endpackage
`default_nettype wire

// ==== logic/pscs_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface pscs_if;
  logic cfg_request_n;
  logic config_serial_clock;
  logic data_bit;
  logic user_startup_clock;
  logic status_o;
  logic status_oe;
  logic done_o;
  logic done_oe;
  logic init_o;
  logic init_oe;
  logic status_n;
  logic conf_done;
  logic init_done;
  // Open-drain wires with pull-ups
  assign status_n  = !(status_oe && !status_o);
  assign conf_done = !(done_oe && !done_o);
  assign init_done = !(init_oe && !init_o);
  modport device (
    input  cfg_request_n, config_serial_clock, data_bit, user_startup_clock,
    output status_o, status_oe, done_o, done_oe, init_o, init_oe,
    input  status_n
  );
  modport host (
    output cfg_request_n, config_serial_clock, data_bit, user_startup_clock,
    input  status_n, conf_done, init_done
  );
endinterface
`default_nettype wire

// ==== logic/pscs_device.sv ====
`timescale 1ns/1ns
`default_nettype none
module pscs_device
  import pscs_pkg::*;
#(
  parameter int POR_CYCLES      = POR_CYC_DEF,
  parameter int BITSTREAM_BYTES = BYTES_DEF
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  pscs_if.device          link,
  input  wire logic       user_clk_option_in,
  output logic [7:0]      cfg_byte_out,
  output logic            cfg_byte_valid_out,
  output logic            user_mode_out
);
  typedef enum logic [2:0] {
    D_POR, D_RESET, D_CONFIG, D_INIT_WAIT, D_STARTUP, D_USER
  } pscs_dstate_type;

  pscs_dstate_type   state;
  logic [1:0]        req_s;
  logic [1:0]        clk_s;
  logic [1:0]        dat_s;
  logic [1:0]        usr_s;
  logic              clk_d;
  logic              usr_d;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  byte_cnt;
  logic [2:0]        bit_idx;
  logic [7:0]        shreg;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              usr_rise;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_s <= 2'h3;
      clk_s <= 2'h0;
      dat_s <= 2'h0;
      usr_s <= 2'h0;
      clk_d <= 1'b0;
      usr_d <= 1'b0;
    end else begin
      req_s <= {req_s[0], link.cfg_request_n};
      clk_s <= {clk_s[0], link.config_serial_clock};
      dat_s <= {dat_s[0], link.data_bit};
      usr_s <= {usr_s[0], link.user_startup_clock};
      clk_d <= clk_s[1];
      usr_d <= usr_s[1];
    end
  end

  assign sclk_rise = clk_s[1] && !clk_d;
  assign sclk_fall = !clk_s[1] && clk_d;
  assign usr_rise  = usr_s[1] && !usr_d;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= D_POR;
      cnt   <= '0;
    end else if (state != D_POR && !req_s[1]) begin
      state <= D_RESET;
      cnt   <= '0;
    end else begin
      case (state)
        D_POR: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(POR_CYCLES - 1)) begin
            state <= D_RESET;
            cnt   <= '0;
          end
        end
        D_RESET: begin
          if (cnt < CNT_W'(STATUS_LOW_CYC - 1)) begin
            cnt <= cnt + 1'b1;
          end else begin
            state <= D_CONFIG;
            cnt   <= '0;
          end
        end
        D_CONFIG: begin
          if (sclk_rise && bit_idx == 3'h7
              && byte_cnt == CNT_W'(BITSTREAM_BYTES - 1)) begin
            state <= D_INIT_WAIT;
            cnt   <= '0;
          end
        end
        D_INIT_WAIT: begin
          if (sclk_fall) begin
            cnt <= cnt + 1'b1;
            if (cnt == CNT_W'(DONE_FALL_EDGES - 1)) begin
              state <= D_STARTUP;
              cnt   <= '0;
            end
          end
        end
        D_STARTUP: begin
          if (user_clk_option_in) begin
            if (usr_rise) begin
              cnt <= cnt + 1'b1;
              if (cnt == CNT_W'(USER_CLK_CYCLES - 1)) begin
                state <= D_USER;
              end
            end
          end else begin
            cnt <= cnt + 1'b1;
            if (cnt == CNT_W'(STARTUP_CYC - 1)) begin
              state <= D_USER;
            end
          end
        end
        D_USER: begin
          cnt <= '0;
        end
        default: begin
          state <= D_POR;
          cnt   <= '0;
        end
      endcase
    end
  end

  // Bit capture and byte assembly
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_idx            <= 3'h0;
      byte_cnt           <= '0;
      shreg              <= 8'h00;
      cfg_byte_out       <= 8'h00;
      cfg_byte_valid_out <= 1'b0;
    end else begin
      cfg_byte_valid_out <= 1'b0;
      if (state != D_CONFIG) begin
        bit_idx  <= 3'h0;
        byte_cnt <= '0;
      end else if (sclk_rise) begin
        shreg   <= {dat_s[1], shreg[7:1]};
        bit_idx <= bit_idx + 1'b1;
        if (bit_idx == 3'h7) begin
          cfg_byte_out       <= {dat_s[1], shreg[7:1]};
          cfg_byte_valid_out <= 1'b1;
          byte_cnt           <= byte_cnt + 1'b1;
        end
      end
    end
  end

  assign link.status_o  = 1'b0;
  assign link.status_oe = (state == D_POR) || (state == D_RESET);
  assign link.done_o    = 1'b0;
  assign link.done_oe   = (state == D_POR) || (state == D_RESET)
                          || (state == D_CONFIG);
  assign link.init_o    = 1'b0;
  assign link.init_oe   = (state != D_USER);
  assign user_mode_out  = (state == D_USER);
endmodule
`default_nettype wire

// ==== logic/pscs_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module pscs_host
  import pscs_pkg::*;
#(
  parameter int HALF_CYC     = SCLK_HALF_CYC,
  parameter int FLUSH_CLOCKS = 64,
  parameter int INIT_TIMEOUT = 20000
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  pscs_if.host            link,
  input  wire logic       start_in,
  input  wire logic       cable_mode_in,
  input  wire logic       user_clk_option_in,
  input  wire logic [7:0] byte_in,
  input  wire logic       byte_valid_in,
  input  wire logic       byte_last_in,
  output logic            byte_ready_out,
  output logic            busy_out,
  output logic            done_out,
  output logic            fail_out
);
  typedef enum logic [3:0] {
    H_IDLE, H_REQ, H_WSTAT, H_GAP, H_LOAD, H_SHIFT, H_FLUSH,
    H_EDGES, H_PRE_USR, H_WINIT, H_OK, H_FAIL
  } pscs_hstate_type;

  pscs_hstate_type   state;
  logic [1:0]        st_s;
  logic [1:0]        dn_s;
  logic [1:0]        in_s;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  aux;
  logic [CNT_W-1:0]  half_cnt;
  logic [CNT_W-1:0]  uhalf_cnt;
  logic              tick;
  logic              utick;
  logic              sclk;
  logic              uclk;
  logic              run_sclk;
  logic              run_uclk;
  logic [7:0]        shreg;
  logic [2:0]        bit_idx;
  logic              last;
  logic              fall_tick;
  logic              link_err;
  logic              data_q;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_s <= 2'h0;
      dn_s <= 2'h0;
      in_s <= 2'h0;
    end else begin
      st_s <= {st_s[0], link.status_n};
      dn_s <= {dn_s[0], link.conf_done};
      in_s <= {in_s[0], link.init_done};
    end
  end

  // Divider, half period well above the fastest legal clock
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      half_cnt <= '0;
    end else if (!run_sclk || tick) begin
      half_cnt <= '0;
    end else begin
      half_cnt <= half_cnt + 1'b1;
    end
  end
  assign tick = run_sclk && (half_cnt == CNT_W'(HALF_CYC - 1));
  assign fall_tick = tick && sclk;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk <= 1'b0;
    end else if (!run_sclk) begin
      sclk <= 1'b0;
    end else if (tick) begin
      sclk <= !sclk;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      uhalf_cnt <= '0;
      uclk      <= 1'b0;
    end else if (!run_uclk) begin
      uhalf_cnt <= '0;
      uclk      <= 1'b0;
    end else if (utick) begin
      uhalf_cnt <= '0;
      uclk      <= !uclk;
    end else begin
      uhalf_cnt <= uhalf_cnt + 1'b1;
    end
  end
  assign utick = (uhalf_cnt == CNT_W'(HALF_CYC - 1));

  assign run_sclk = (state == H_SHIFT) || (state == H_FLUSH) || (state == H_EDGES);
  assign run_uclk = (state == H_WINIT) && user_clk_option_in && !cable_mode_in;
  assign link_err = !st_s[1] && ((state == H_LOAD) || (state == H_SHIFT)
                    || (state == H_FLUSH));

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state   <= H_IDLE;
      cnt     <= '0;
      aux     <= '0;
      bit_idx <= 3'h0;
      shreg   <= 8'h00;
      last    <= 1'b0;
    end else if (link_err) begin
      state <= H_FAIL;
    end else begin
      case (state)
        H_IDLE, H_OK: begin
          if (start_in) begin
            state <= H_REQ;
            cnt   <= '0;
          end
        end
        H_REQ: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(REQ_LOW_CYC - 1)) begin
            state <= H_WSTAT;
            cnt   <= '0;
          end
        end
        H_WSTAT: begin
          cnt <= cnt + 1'b1;
          aux <= '0;
          if (st_s[1]) begin
            state <= H_GAP;
          end
        end
        H_GAP: begin
          if (cnt < CNT_W'(REQ2CLK_CYC)) begin
            cnt <= cnt + 1'b1;
          end
          if (aux < CNT_W'(ST2CLK_CYC)) begin
            aux <= aux + 1'b1;
          end
          if (cnt >= CNT_W'(REQ2CLK_CYC) && aux >= CNT_W'(ST2CLK_CYC)) begin
            state <= H_LOAD;
          end
        end
        H_LOAD: begin
          if (byte_valid_in) begin
            shreg   <= byte_in;
            last    <= byte_last_in;
            bit_idx <= 3'h0;
            state   <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (fall_tick) begin
            shreg   <= {1'b0, shreg[7:1]};
            bit_idx <= bit_idx + 1'b1;
            if (bit_idx == 3'h7) begin
              state <= last ? H_FLUSH : H_LOAD;
              cnt   <= '0;
            end
          end
        end
        H_FLUSH: begin
          if (dn_s[1]) begin
            state <= H_EDGES;
            cnt   <= '0;
          end else if (fall_tick) begin
            // Counted on falls so a give-up never cuts a high phase short
            cnt <= cnt + 1'b1;
            if (cnt == CNT_W'(FLUSH_CLOCKS - 1)) begin
              state <= H_FAIL;
            end
          end
        end
        H_EDGES: begin
          if (fall_tick) begin
            cnt <= cnt + 1'b1;
            if (cnt == CNT_W'(DONE_FALL_EDGES - 1)) begin
              state <= (user_clk_option_in && !cable_mode_in) ? H_PRE_USR : H_WINIT;
              cnt   <= '0;
            end
          end
        end
        H_PRE_USR: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(PRE_USER_PERIODS * 2 * HALF_CYC - 1)) begin
            state <= H_WINIT;
            cnt   <= '0;
          end
        end
        H_WINIT: begin
          cnt <= cnt + 1'b1;
          if (in_s[1]) begin
            state <= H_OK;
          end else if (cnt == CNT_W'(INIT_TIMEOUT - 1)) begin
            state <= H_FAIL;
          end
        end
        H_FAIL: begin
          if (!cable_mode_in || start_in) begin
            state <= H_REQ;
            cnt   <= '0;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link.cfg_request_n <= 1'b1;
    end else begin
      link.cfg_request_n <= !(state == H_REQ);
    end
  end

  // Data changes only while the clock is low (falling edges or in H_LOAD) or on a link error, steady low when idle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_q <= 1'b0;
    end else if (link_err) begin
      data_q <= 1'b0;
    end else if (state == H_LOAD && byte_valid_in) begin
      data_q <= byte_in[0];
    end else if (state == H_SHIFT && fall_tick) begin
      data_q <= shreg[1];
    end else if (state != H_SHIFT) begin
      data_q <= 1'b0;
    end
  end

  assign link.data_bit           = data_q;
  assign link.config_serial_clock = sclk;
  assign link.user_startup_clock  = uclk;
  assign byte_ready_out = (state == H_LOAD);
  assign busy_out       = (state != H_IDLE) && (state != H_OK) && (state != H_FAIL);
  assign done_out       = (state == H_OK);
  assign fail_out       = (state == H_FAIL);
endmodule
`default_nettype wire

// ==== verification/pscs_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module pscs_chk
  import pscs_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic cfg_request_n,
  input wire logic config_serial_clock,
  input wire logic data_bit,
  input wire logic user_startup_clock,
  input wire logic status_n,
  input wire logic conf_done,
  input wire logic init_done
);
  logic [15:0] stlo_cnt;
  logic [15:0] sthi_cnt;
  logic [15:0] req_cnt;
  logic [15:0] done_cnt;
  logic [15:0] ucnt;
  logic        seen_clk;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // Cycles spent in the current status level
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stlo_cnt <= 16'h0;
      sthi_cnt <= 16'h0;
    end else begin
      stlo_cnt <= status_n ? 16'h0 : stlo_cnt + {15'h0, stlo_cnt != 16'hFFFF};
      sthi_cnt <= !status_n ? 16'h0 : sthi_cnt + {15'h0, sthi_cnt != 16'hFFFF};
    end
  end

  // Time since request release, first clock seen
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_cnt  <= 16'h0;
      seen_clk <= 1'b0;
    end else begin
      req_cnt  <= !cfg_request_n ? 16'h0 : req_cnt + {15'h0, req_cnt != 16'hFFFF};
      seen_clk <= cfg_request_n && (seen_clk || $rose(config_serial_clock));
    end
  end

  // Time and user clock rises since done went high
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_cnt <= 16'h0;
      ucnt     <= 16'h0;
    end else begin
      done_cnt <= !conf_done ? 16'h0 : done_cnt + {15'h0, done_cnt != 16'hFFFF};
      ucnt     <= !conf_done ? 16'h0 : ucnt + {15'h0, $rose(user_startup_clock)};
    end
  end

  sequence req_low_s;
    !cfg_request_n [*5];
  endsequence

  sequence two_falls_s;
    ##[1:12] $fell(config_serial_clock) ##[1:12] $fell(config_serial_clock);
  endsequence

  req_width_a: assert property ($fell(cfg_request_n) |-> req_low_s)
    else $error("request pulse too short");
  req_restart_a: assert property ($fell(cfg_request_n) |-> ##[0:8]
    (!status_n && !conf_done && !init_done)) else $error("no restart on request");
  status_low_a: assert property ($rose(status_n) |-> stlo_cnt >= STATUS_LOW_CYC - 1)
    else $error("status low too short");
  done_low_a: assert property (!status_n |-> !conf_done)
    else $error("done high during reset");
  first_clk_a: assert property ($rose(config_serial_clock) && !seen_clk |->
    req_cnt >= REQ2CLK_CYC - 1 && sthi_cnt >= ST2CLK_CYC - 1 && !conf_done)
    else $error("first clock too early");
  clk_rate_a: assert property ($rose(config_serial_clock) |->
    config_serial_clock [*4] ##1 !config_serial_clock) else $error("clock high time wrong");
  init_falls_a: assert property ($rose(conf_done) |-> two_falls_s)
    else $error("missing falls after done");
  user_wait_a: assert property ($rose(user_startup_clock) |->
    done_cnt >= PRE_USER_PERIODS * 2 * SCLK_HALF_CYC) else $error("user clock too early");
  startup_time_a: assert property ($rose(init_done) |-> done_cnt >= STARTUP_CYC)
    else $error("user mode too early");
  user_cnt_a: assert property ($rose(init_done) && ucnt != 16'h0 |->
    ucnt >= USER_CLK_CYCLES && ucnt <= USER_CLK_CYCLES + 4) else $error("user clock count");
  idle_lines_a: assert property (init_done && $past(init_done) && cfg_request_n |->
    $stable(config_serial_clock) && $stable(data_bit)) else $error("lines moved in user mode");
  user_hold_a: assert property (init_done && cfg_request_n |=> init_done)
    else $error("init dropped in user mode");
endmodule
`default_nettype wire

// ==== verification/pscs_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module pscs_bench
  import pscs_pkg::*;
  ;
  logic       clk_in;
  logic       resetn_in;
  logic       start_in;
  logic       cable_mode_in;
  logic       host_uopt;
  logic       dev_uopt;
  logic [7:0] byte_in;
  logic       byte_valid_in;
  logic       byte_last_in;
  logic       byte_ready_out;
  logic       busy_out;
  logic       done_out;
  logic       fail_out;
  logic [7:0] cfg_byte_out;
  logic       cfg_byte_valid_out;
  logic       user_mode_out;
  int         num_errors;
  int         cmp_count;
  int         ucnt;
  int         nb;
  logic [7:0] sh;
  logic       sclk_q;
  logic       usr_q;
  logic [7:0] dev_q[$];
  logic [7:0] wire_q[$];

  pscs_if link_if();

  pscs_host #(.FLUSH_CLOCKS(64), .INIT_TIMEOUT(30000)) pscs_host_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .link(link_if), .start_in(start_in),
    .cable_mode_in(cable_mode_in), .user_clk_option_in(host_uopt), .byte_in(byte_in),
    .byte_valid_in(byte_valid_in), .byte_last_in(byte_last_in),
    .byte_ready_out(byte_ready_out), .busy_out(busy_out), .done_out(done_out),
    .fail_out(fail_out));

  pscs_device #(.POR_CYCLES(20), .BITSTREAM_BYTES(12)) pscs_device_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .link(link_if), .user_clk_option_in(dev_uopt),
    .cfg_byte_out(cfg_byte_out), .cfg_byte_valid_out(cfg_byte_valid_out),
    .user_mode_out(user_mode_out));

  pscs_chk pscs_chk_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .cfg_request_n(link_if.cfg_request_n),
    .config_serial_clock(link_if.config_serial_clock), .data_bit(link_if.data_bit),
    .user_startup_clock(link_if.user_startup_clock), .status_n(link_if.status_n),
    .conf_done(link_if.conf_done), .init_done(link_if.init_done));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Collects device bytes and rebuilds bytes seen on the wire
  always @(posedge clk_in) begin
    if (cfg_byte_valid_out === 1'b1) dev_q.push_back(cfg_byte_out);
    usr_q <= link_if.user_startup_clock;
    sclk_q <= link_if.config_serial_clock;
    if (link_if.user_startup_clock && !usr_q) ucnt++;
    if (!link_if.cfg_request_n) nb = 0;
    else if (link_if.config_serial_clock && !sclk_q && !link_if.conf_done) begin
      sh = {link_if.data_bit, sh[7:1]};
      nb++;
      if (nb % 8 == 0) wire_q.push_back(sh);
    end
  end

  task report_and_stop();
    $display("errors %0d, compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task wait_on(input int sel, input int lim);
    bit hit;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(negedge clk_in);
      case (sel)
        0: hit = byte_ready_out;
        1: hit = done_out || fail_out;
        default: hit = !user_mode_out;
      endcase
    end
    if (!hit) begin
      num_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask

  task send_byte(input logic [7:0] b, input logic last);
    @(posedge clk_in);
    byte_in <= b;
    byte_valid_in <= 1'b1;
    byte_last_in <= last;
    wait_on(0, 5000);
    @(posedge clk_in);
    byte_valid_in <= 1'b0;
    byte_last_in <= 1'b0;
  endtask

  task run(input logic cable, hopt, dopt, input logic [7:0] base, input int n, input bit ok);
    int u0;
    u0 = ucnt;
    dev_q.delete();
    wire_q.delete();
    @(posedge clk_in);
    cable_mode_in <= cable;
    host_uopt <= hopt;
    dev_uopt <= dopt;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    wait_on(2, 30);
    `CHK(user_mode_out, 1'b0, "user mode kept after request")
    `CHK(busy_out, 1'b1, "host idle after start")
    for (int k = 0; k < n; k++) send_byte(base + 8'h1B * k[7:0], k == n - 1);
    wait_on(1, 40000);
    if (ok) begin
      `CHK(done_out, 1'b1, "host not done")
      `CHK(busy_out, 1'b0, "host still busy")
      `CHK(user_mode_out, 1'b1, "no user mode")
      `CHK(link_if.init_done, 1'b1, "init line low")
      `CHK(ucnt == u0, !(hopt && !cable), "user clock use")
      `CHK(ucnt - u0 >= USER_CLK_CYCLES, hopt && !cable, "user clock count")
      for (int k = 0; k < n; k++) begin
        `CHK(dev_q[k], base + 8'h1B * k[7:0], "device byte")
        `CHK(wire_q[k], base + 8'h1B * k[7:0], "wire bit order")
      end
    end else begin
      `CHK(fail_out, 1'b1, "short stream not failed")
      `CHK(busy_out, 1'b0, "busy after failure")
      `CHK(link_if.conf_done, 1'b0, "done with short stream")
      repeat (600) @(posedge clk_in);
      `CHK(link_if.cfg_request_n, 1'b1, "restarted without start")
      `CHK(fail_out, 1'b1, "failure not held")
    end
  endtask

  initial begin
    resetn_in = 1'b0;
    start_in = 1'b0;
    cable_mode_in = 1'b0;
    host_uopt = 1'b0;
    dev_uopt = 1'b0;
    byte_in = 8'h00;
    byte_valid_in = 1'b0;
    byte_last_in = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    ucnt = 0;
    nb = 0;
    sh = 8'h00;
    sclk_q = 1'b0;
    usr_q = 1'b0;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    `CHK(link_if.status_n, 1'b0, "status released in power-on")
    `CHK(link_if.conf_done, 1'b0, "done high in power-on")
    run(1'b0, 1'b0, 1'b0, 8'h02, 12, 1'b1);
    run(1'b0, 1'b1, 1'b1, 8'hEE, 12, 1'b1);
    run(1'b1, 1'b0, 1'b0, 8'hFA, 2, 1'b0);
    run(1'b1, 1'b1, 1'b0, 8'h5A, 12, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
